//--- design/sbl_pkg.sv
package sbl_pkg;

  // transaction class carried with each strobe
  typedef struct packed {
    logic fetch;
    logic rd;
    logic wr;
    logic lock;
    logic unlockReq;
  } sbl_kind_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ISSUE,
    S_WAIT
  } sbl_state_t;

  localparam sbl_kind_t SBL_KIND_RESET = 5'h00;
  localparam sbl_kind_t SBL_KIND_FETCH = 5'h18;
  localparam logic SBL_FLAG_RESET = 1'b0;

endpackage : sbl_pkg

//--- design/sbl_side_if.sv
`timescale 1ns/10ps
interface sbl_side_if;
  import sbl_pkg::*;

  logic start;
  sbl_kind_t startKind;
  logic waitRequest;
  logic issueHit;
  logic valueHit;
  logic releaseStatusIn;
  logic debugReturn;
  logic readStrobe;
  logic writeStrobe;
  logic instrFlag;
  logic lockInd;
  logic releaseInd;
  logic breakFlag;
  logic breakOnFetch;
  logic done;
  logic idle;
  logic relValid;
  logic relStatus;

  modport core (
    output start, startKind, waitRequest, issueHit, valueHit, releaseStatusIn, debugReturn,
    input readStrobe, writeStrobe, instrFlag, lockInd, releaseInd, breakFlag, breakOnFetch,
    input done, idle, relValid, relStatus
  );

  modport port (
    input start, startKind, waitRequest, issueHit, valueHit, releaseStatusIn, debugReturn,
    output readStrobe, writeStrobe, instrFlag, lockInd, releaseInd, breakFlag, breakOnFetch,
    output done, idle, relValid, relStatus
  );

endinterface : sbl_side_if

//--- design/sbl_side_port.sv
`timescale 1ns/10ps
module sbl_side_port
  import sbl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // one side of the memory interface
  sbl_side_if.port sp
);

  sbl_state_t state_r, state_nxt;
  sbl_kind_t kind_r, saved_r;
  logic replay_r;
  logic readStb_r, writeStb_r, instrStb_r, lockStb_r, relStb_r;
  logic brk_r, brkFetch_r, done_r, idle_r, relValid_r, relStatus_r;

  wire logic idleNow;
  wire logic launchReplay;
  wire logic launchNew;
  wire logic launch;
  wire sbl_kind_t launchKind;
  wire logic ended;
  wire logic issueBreak;
  wire logic valueBreak;
  wire logic brk;
  wire logic scEnd;

  assign idleNow = (state_r == S_IDLE);
  // a pending replay blocks new work until the debug handler returns
  assign launchReplay = idleNow & replay_r & sp.debugReturn;
  assign launchNew = idleNow & ~replay_r & sp.start;
  assign launch = launchReplay | launchNew;
  assign launchKind = launchReplay ? saved_r : sp.startKind;
  // wait request masks every other input of the agent
  assign ended = (state_r == S_WAIT) & ~sp.waitRequest;
  // flag follows the strobe cycle; nothing is acknowledged back
  assign issueBreak = (state_r == S_ISSUE) & sp.issueHit;
  // value breaks are known only once the read data is in
  assign valueBreak = ended & kind_r.rd & ~kind_r.fetch & sp.valueHit;
  assign brk = issueBreak | valueBreak;
  assign scEnd = ended & kind_r.unlockReq;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: if (launch) state_nxt = S_ISSUE;
      S_ISSUE: state_nxt = S_WAIT;
      // stays here until the agent drops its wait request
      S_WAIT: if (ended) state_nxt = S_IDLE;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= S_IDLE;
      kind_r <= SBL_KIND_RESET;
      saved_r <= SBL_KIND_RESET;
      replay_r <= SBL_FLAG_RESET;
    end
    else
    begin
      state_r <= state_nxt;
      kind_r <= launch ? launchKind : kind_r;
      saved_r <= brk ? kind_r : saved_r;
      // a new break wins over the replay launch clearing it
      replay_r <= brk | (replay_r & ~launchReplay);
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      readStb_r <= SBL_FLAG_RESET;
      writeStb_r <= SBL_FLAG_RESET;
      instrStb_r <= SBL_FLAG_RESET;
      lockStb_r <= SBL_FLAG_RESET;
      relStb_r <= SBL_FLAG_RESET;
    end
    else
    begin
      readStb_r <= launch & launchKind.rd;
      writeStb_r <= launch & launchKind.wr;
      instrStb_r <= launch & launchKind.fetch;
      lockStb_r <= launch & launchKind.rd & launchKind.lock;
      relStb_r <= launch & launchKind.wr & launchKind.unlockReq;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      brk_r <= SBL_FLAG_RESET;
      brkFetch_r <= SBL_FLAG_RESET;
      done_r <= SBL_FLAG_RESET;
      idle_r <= SBL_FLAG_RESET;
      relValid_r <= SBL_FLAG_RESET;
      relStatus_r <= SBL_FLAG_RESET;
    end
    else
    begin
      brk_r <= brk;
      brkFetch_r <= brk & kind_r.fetch;
      done_r <= ended;
      idle_r <= (state_nxt == S_IDLE) & ~(brk | (replay_r & ~launchReplay));
      relValid_r <= scEnd;
      relStatus_r <= scEnd ? sp.releaseStatusIn : relStatus_r;
    end
  end

  assign sp.readStrobe = readStb_r;
  assign sp.writeStrobe = writeStb_r;
  assign sp.instrFlag = instrStb_r;
  assign sp.lockInd = lockStb_r;
  assign sp.releaseInd = relStb_r;
  assign sp.breakFlag = brk_r;
  assign sp.breakOnFetch = brkFetch_r;
  assign sp.done = done_r;
  assign sp.idle = idle_r;
  assign sp.relValid = relValid_r;
  assign sp.relStatus = relStatus_r;

  property p_replay_kind;
    @(posedge clk) disable iff (!resetn)
    launchReplay |=> (kind_r == $past(saved_r)) && (state_r == S_ISSUE);
  endproperty
  a_replay_kind: assert property (p_replay_kind) else $error("replay lost its kind");

  property p_status_hold;
    @(posedge clk) disable iff (!resetn)
    !scEnd |=> $stable(relStatus_r) && !relValid_r;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status taken off end");

  property p_wait_masks;
    @(posedge clk) disable iff (!resetn)
    (state_r == S_WAIT && sp.waitRequest) |=> !done_r ##0 (state_r == S_WAIT);
  endproperty
  a_wait_masks: assert property (p_wait_masks) else $error("ended during wait");

endmodule : sbl_side_port

//--- design/sbl_break_lock.sv
`timescale 1ns/10ps
// How it works
// - debug exception taken on the issuing instruction
// - breakpointed transaction reissued after debug return
// - break flags get no acknowledge
// - value break flagged cycle after read ends
// - data break enable held while enabled, outside unified mode
// - write break flag in cycle after strobe
// - unified data write: write strobe only
// - unified enable covers both; data breaks fetch-side
// - lock indicator with load-linked read strobe
// - release indicator with store-conditional write strobe
// - release status returned as store-conditional result
// - routed lock operations use fetch-side signals
// - one-cycle release-every-lock on exception return
// - inputs ignored while wait request high
// - transaction ends first cycle without wait
module sbl_break_lock
  import sbl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // configuration levels
  input wire logic unifiedMode,
  input wire logic dataOnFetchSide,
  // pipeline requests
  input wire logic dataStart,
  input wire sbl_kind_t dataKind,
  input wire logic fetchStart,
  input wire logic debugReturn,
  input wire logic exceptionReturn,
  // debug breakpoint logic
  input wire logic dataBreakEnabled,
  input wire logic instrBreakEnabled,
  input wire logic dataIssueHit,
  input wire logic dataValueHit,
  input wire logic fetchIssueHit,
  // pipeline answers
  output logic dataIdle,
  output logic fetchIdle,
  output logic dataDone,
  output logic fetchDone,
  output logic debugException,
  output logic debugOnFetch,
  output logic scResultValid,
  output logic scResult,
  // data side pins
  output logic dataSideReadStrobe,
  output logic dataSideWriteStrobe,
  output logic dataSideLockIndicator,
  output logic dataSideReleaseIndicator,
  output logic dataSideBreakFlag,
  output logic dataSideBreakEnable,
  input wire logic dataSideWaitRequest,
  input wire logic dataSideReleaseStatus,
  // fetch side pins
  output logic fetchSideReadStrobe,
  output logic fetchSideWriteStrobe,
  output logic fetchSideInstructionFlag,
  output logic fetchSideLockIndicator,
  output logic fetchSideReleaseIndicator,
  output logic fetchSideBreakFlag,
  output logic fetchSideBreakEnable,
  output logic fetchSideReleaseEveryLock,
  input wire logic fetchSideWaitRequest,
  input wire logic fetchSideReleaseStatus
);

  sbl_side_if dPort();
  sbl_side_if fPort();

  logic dEnable_r, fEnable_r, releaseAll_r;
  logic dbgExc_r, dbgOnFetch_r, scValid_r, scResult_r;

  wire logic useFetch;
  wire logic dataToFetch;
  wire sbl_kind_t dataKindClean;

  // data operations never carry the fetch marker
  assign dataKindClean = '{fetch: 1'b0, rd: dataKind.rd, wr: dataKind.wr,
                           lock: dataKind.lock, unlockReq: dataKind.unlockReq};
  assign useFetch = unifiedMode | dataOnFetchSide;
  assign dataToFetch = dataStart & useFetch;

  assign dPort.start = dataStart & ~useFetch;
  assign dPort.startKind = dataKindClean;
  assign dPort.waitRequest = dataSideWaitRequest;
  assign dPort.issueHit = dataIssueHit & ~useFetch;
  assign dPort.valueHit = dataValueHit & ~useFetch;
  assign dPort.releaseStatusIn = dataSideReleaseStatus;
  assign dPort.debugReturn = debugReturn;

  // a routed data operation takes the fetch side ahead of a fetch
  assign fPort.start = fetchStart | dataToFetch;
  assign fPort.startKind = dataToFetch ? dataKindClean : SBL_KIND_FETCH;
  assign fPort.waitRequest = fetchSideWaitRequest;
  assign fPort.issueHit = fetchIssueHit | (dataIssueHit & useFetch);
  assign fPort.valueHit = dataValueHit & useFetch;
  assign fPort.releaseStatusIn = fetchSideReleaseStatus;
  assign fPort.debugReturn = debugReturn;

  sbl_side_port u_dataSide (
    .clk(clk),
    .resetn(resetn),
    .sp(dPort.port)
  );

  sbl_side_port u_fetchSide (
    .clk(clk),
    .resetn(resetn),
    .sp(fPort.port)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dEnable_r <= SBL_FLAG_RESET;
      fEnable_r <= SBL_FLAG_RESET;
      releaseAll_r <= SBL_FLAG_RESET;
    end
    else
    begin
      // enables follow the debug settings, not any one transaction
      dEnable_r <= dataBreakEnabled & ~unifiedMode;
      fEnable_r <= instrBreakEnabled | (unifiedMode & dataBreakEnabled);
      releaseAll_r <= exceptionReturn;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      dbgExc_r <= SBL_FLAG_RESET;
      dbgOnFetch_r <= SBL_FLAG_RESET;
      scValid_r <= SBL_FLAG_RESET;
      scResult_r <= SBL_FLAG_RESET;
    end
    else
    begin
      dbgExc_r <= dPort.breakFlag | fPort.breakFlag;
      dbgOnFetch_r <= fPort.breakOnFetch;
      scValid_r <= dPort.relValid | fPort.relValid;
      if (dPort.relValid)
        scResult_r <= dPort.relStatus;
      else if (fPort.relValid)
        scResult_r <= fPort.relStatus;
    end
  end

  assign dataIdle = dPort.idle;
  assign fetchIdle = fPort.idle;
  assign dataDone = dPort.done;
  assign fetchDone = fPort.done;
  assign debugException = dbgExc_r;
  assign debugOnFetch = dbgOnFetch_r;
  assign scResultValid = scValid_r;
  assign scResult = scResult_r;
  assign dataSideReadStrobe = dPort.readStrobe;
  assign dataSideWriteStrobe = dPort.writeStrobe;
  assign dataSideLockIndicator = dPort.lockInd;
  assign dataSideReleaseIndicator = dPort.releaseInd;
  assign dataSideBreakFlag = dPort.breakFlag;
  assign dataSideBreakEnable = dEnable_r;
  assign fetchSideReadStrobe = fPort.readStrobe;
  assign fetchSideWriteStrobe = fPort.writeStrobe;
  assign fetchSideInstructionFlag = fPort.instrFlag;
  assign fetchSideLockIndicator = fPort.lockInd;
  assign fetchSideReleaseIndicator = fPort.releaseInd;
  assign fetchSideBreakFlag = fPort.breakFlag;
  assign fetchSideBreakEnable = fEnable_r;
  assign fetchSideReleaseEveryLock = releaseAll_r;

  property p_write_break;
    @(posedge clk) disable iff (!resetn)
    (dataSideWriteStrobe && dataIssueHit && !useFetch) |=> dataSideBreakFlag;
  endproperty
  a_write_break: assert property (p_write_break) else $error("no break after write strobe");

  property p_break_to_exc;
    @(posedge clk) disable iff (!resetn)
    (dataSideBreakFlag || fetchSideBreakFlag) |=> debugException;
  endproperty
  a_break_to_exc: assert property (p_break_to_exc) else $error("break not taken");

  property p_value_break;
    @(posedge clk) disable iff (!resetn)
    (dataSideReadStrobe && !useFetch) ##1 (!dataSideWaitRequest && dataValueHit && !useFetch)
      |=> dataSideBreakFlag;
  endproperty
  a_value_break: assert property (p_value_break) else $error("value break late");

  property p_data_enable;
    @(posedge clk) disable iff (!resetn)
    ($past(dataBreakEnabled) && !$past(unifiedMode)) |-> dataSideBreakEnable;
  endproperty
  a_data_enable: assert property (p_data_enable) else $error("data enable dropped");

  property p_fetch_enable;
    @(posedge clk) disable iff (!resetn)
    ($past(unifiedMode) && ($past(dataBreakEnabled) || $past(instrBreakEnabled)))
      |-> fetchSideBreakEnable;
  endproperty
  a_fetch_enable: assert property (p_fetch_enable) else $error("unified enable low");

  property p_unified_write;
    @(posedge clk) disable iff (!resetn)
    fetchSideWriteStrobe |-> !fetchSideReadStrobe && !fetchSideInstructionFlag;
  endproperty
  a_unified_write: assert property (p_unified_write) else $error("write marked as read");

  property p_lock_read;
    @(posedge clk) disable iff (!resetn)
    (dataStart && dataIdle && !useFetch && dataKind.rd && dataKind.lock)
      |=> dataSideLockIndicator && dataSideReadStrobe;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock not with read");

  property p_release_write;
    @(posedge clk) disable iff (!resetn)
    (dataSideReleaseIndicator || fetchSideReleaseIndicator)
      |-> (dataSideReleaseIndicator ? dataSideWriteStrobe : fetchSideWriteStrobe);
  endproperty
  a_release_write: assert property (p_release_write) else $error("release without write");

  property p_sc_result;
    @(posedge clk) disable iff (!resetn)
    (dataSideWriteStrobe && dataSideReleaseIndicator) ##1 (!dataSideWaitRequest)
      |=> ##1 (scResultValid && scResult == $past(dataSideReleaseStatus, 2));
  endproperty
  a_sc_result: assert property (p_sc_result) else $error("wrong store result");

  property p_release_all;
    @(posedge clk) disable iff (!resetn)
    exceptionReturn ##1 !exceptionReturn |-> fetchSideReleaseEveryLock ##1 !fetchSideReleaseEveryLock;
  endproperty
  a_release_all: assert property (p_release_all) else $error("release-all not one cycle");

endmodule : sbl_break_lock

//--- testbench/sbl_mem_agent.sv
`timescale 1ns/10ps
module sbl_mem_agent
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // strobes and flags from the core
  input wire logic readStrobe,
  input wire logic writeStrobe,
  input wire logic lockInd,
  input wire logic breakEnable,
  input wire logic breakFlag,
  input wire logic releaseEveryLock,
  // behaviour chosen by the bench
  input wire logic [3:0] waitCycles,
  input wire logic keepLock,
  // answers to the core, and whether a write reached memory
  output logic waitRequest,
  output logic releaseStatus,
  output logic stored
);
  logic busy_r;
  logic [3:0] left_r;
  logic junk_r;
  logic wr_r, guard_r, flagged_r, lockHeld_r, stored_r;
  wire logic endCycle = busy_r && (left_r == 4'h0);
  // writes are guarded only while breaks are enabled, so a flagged one never lands
  wire logic blocked = guard_r && (flagged_r || breakFlag);
  // always lets go in the end, breakpointed or not; break flags get no answer at all
  assign waitRequest = busy_r && (left_r != 4'h0);
  // locks are not tied to addresses; status flips every cycle outside the end cycle
  assign releaseStatus = endCycle ? (keepLock && lockHeld_r) : junk_r;
  assign stored = stored_r;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_r <= 1'b0;
      left_r <= 4'h0;
      junk_r <= 1'b0;
      wr_r <= 1'b0;
      guard_r <= 1'b0;
      flagged_r <= 1'b0;
      lockHeld_r <= 1'b0;
      stored_r <= 1'b0;
    end
    else
    begin
      junk_r <= ~junk_r;
      stored_r <= endCycle && wr_r && !blocked;
      // one lock per agent, not one shared by both sides, dropped on release-every-lock
      lockHeld_r <= !releaseEveryLock && (lockHeld_r || (readStrobe && lockInd));
      flagged_r <= !(readStrobe || writeStrobe) && (flagged_r || breakFlag);
      if (readStrobe || writeStrobe)
      begin
        busy_r <= 1'b1;
        left_r <= waitCycles;
        wr_r <= writeStrobe;
        guard_r <= breakEnable;
      end
      else if (endCycle)
        busy_r <= 1'b0;
      else if (busy_r)
        left_r <= left_r - 4'h1;
    end
  end
endmodule : sbl_mem_agent

//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import sbl_pkg::*;
;
  typedef struct {
    logic [1:0] rt;
    sbl_kind_t kind;
    logic [3:0] nw;
    logic ih, vh, rel, brk;
  } sbl_tb_row_t;
  logic clk, resetn, unifiedMode, dataOnFetchSide, dataStart, fetchStart, debugReturn;
  logic exceptionReturn, dataBreakEnabled, instrBreakEnabled, dataIssueHit, dataValueHit;
  logic fetchIssueHit, dataSideWaitRequest, dataSideReleaseStatus, keepLock;
  logic fetchSideWaitRequest, fetchSideReleaseStatus;
  sbl_kind_t dataKind;
  logic [3:0] waitN;
  logic dataIdle, fetchIdle, dataDone, fetchDone, debugException, debugOnFetch, scResultValid;
  logic scResult, dataSideReadStrobe, dataSideWriteStrobe, dataSideLockIndicator;
  logic dataSideReleaseIndicator, dataSideBreakFlag, dataSideBreakEnable, fetchSideReadStrobe;
  logic fetchSideWriteStrobe, fetchSideInstructionFlag, fetchSideLockIndicator;
  logic fetchSideReleaseIndicator, fetchSideBreakFlag, fetchSideBreakEnable;
  logic fetchSideReleaseEveryLock;
  logic dataStored, fetchStored;
  int numErrors = 0;
  int totalChecks = 0;
  sbl_tb_row_t rows [11] = '{
    '{2'd0, 5'h08, 4'd0, 0, 0, 0, 0}, '{2'd0, 5'h0a, 4'd1, 0, 0, 0, 0},
    '{2'd0, 5'h05, 4'd2, 0, 0, 1, 0}, '{2'd0, 5'h05, 4'd0, 0, 0, 0, 0},
    '{2'd0, 5'h04, 4'd1, 1, 0, 0, 1}, '{2'd2, 5'h04, 4'd1, 1, 0, 0, 1},
    '{2'd0, 5'h08, 4'd1, 0, 1, 0, 1}, '{2'd0, 5'h04, 4'd1, 0, 1, 0, 0},
    '{2'd1, 5'h0a, 4'd0, 0, 0, 0, 0}, '{2'd2, 5'h05, 4'd1, 0, 0, 1, 0},
    '{2'd1, 5'h08, 4'd2, 0, 1, 0, 1}};
  // the side a data operation lands on, and the one it must leave alone
  wire logic fs = unifiedMode | dataOnFetchSide;
  wire logic uRd = fs ? fetchSideReadStrobe : dataSideReadStrobe;
  wire logic uWr = fs ? fetchSideWriteStrobe : dataSideWriteStrobe;
  wire logic uLk = fs ? fetchSideLockIndicator : dataSideLockIndicator;
  wire logic uRl = fs ? fetchSideReleaseIndicator : dataSideReleaseIndicator;
  wire logic uBrk = fs ? fetchSideBreakFlag : dataSideBreakFlag;
  wire logic uIdle = fs ? fetchIdle : dataIdle;
  wire logic uDone = fs ? fetchDone : dataDone;
  wire logic uSt = fs ? fetchStored : dataStored;
  wire logic oAny = fs ? (dataSideReadStrobe | dataSideWriteStrobe | dataSideBreakFlag)
    : (fetchSideReadStrobe | fetchSideWriteStrobe | fetchSideBreakFlag);

  sbl_break_lock dut (.clk, .resetn, .unifiedMode, .dataOnFetchSide, .dataStart, .dataKind,
    .fetchStart, .debugReturn, .exceptionReturn, .dataBreakEnabled, .instrBreakEnabled,
    .dataIssueHit, .dataValueHit, .fetchIssueHit, .dataIdle, .fetchIdle, .dataDone, .fetchDone,
    .debugException, .debugOnFetch, .scResultValid, .scResult, .dataSideReadStrobe,
    .dataSideWriteStrobe, .dataSideLockIndicator, .dataSideReleaseIndicator, .dataSideBreakFlag,
    .dataSideBreakEnable, .dataSideWaitRequest, .dataSideReleaseStatus, .fetchSideReadStrobe,
    .fetchSideWriteStrobe, .fetchSideInstructionFlag, .fetchSideLockIndicator,
    .fetchSideReleaseIndicator, .fetchSideBreakFlag, .fetchSideBreakEnable,
    .fetchSideReleaseEveryLock, .fetchSideWaitRequest, .fetchSideReleaseStatus);
  sbl_mem_agent dataAgent (.clk, .resetn, .readStrobe(dataSideReadStrobe),
    .writeStrobe(dataSideWriteStrobe), .lockInd(dataSideLockIndicator),
    .breakEnable(dataSideBreakEnable), .breakFlag(dataSideBreakFlag), .releaseEveryLock(1'b0),
    .waitCycles(waitN), .keepLock, .waitRequest(dataSideWaitRequest),
    .releaseStatus(dataSideReleaseStatus), .stored(dataStored));
  sbl_mem_agent fetchAgent (.clk, .resetn, .readStrobe(fetchSideReadStrobe),
    .writeStrobe(fetchSideWriteStrobe), .lockInd(fetchSideLockIndicator),
    .breakEnable(fetchSideBreakEnable), .breakFlag(fetchSideBreakFlag),
    .releaseEveryLock(fetchSideReleaseEveryLock), .waitCycles(waitN), .keepLock,
    .waitRequest(fetchSideWaitRequest), .releaseStatus(fetchSideReleaseStatus),
    .stored(fetchStored));

  task automatic check(input logic seen, input logic exp, input string what);
    totalChecks++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("ERROR %0t %s seen %b expected %b", $time, what, seen, exp);
    end
  endtask : check

  task automatic conclude();
    if (numErrors == 0 && totalChecks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic run(input sbl_tb_row_t r);
    int e;
    int k;
    e = 2 + int'(r.nw);
    @(posedge clk);
    unifiedMode <= (r.rt == 2'd2);
    dataOnFetchSide <= (r.rt == 2'd1);
    waitN <= r.nw;
    keepLock <= r.rel;
    k = 0;
    do @(negedge clk); while (uIdle !== 1'b1 && ++k < 50);
    @(posedge clk);
    dataStart <= 1'b1;
    dataKind <= r.kind;
    dataIssueHit <= r.ih;
    dataValueHit <= r.vh;
    @(posedge clk);
    dataStart <= 1'b0;
    for (k = 1; k < 10; k++)
    begin
      @(negedge clk);
      check(uRd | uWr, k == 1, "strobe");
      check(uLk, uRd & r.kind.lock, "lock");
      check(uRl, uWr & r.kind.unlockReq, "release");
      check(oAny, 1'b0, "other side");
      check(fetchSideInstructionFlag, 1'b0, "instr flag");
      check(uBrk, r.brk && k == (r.vh ? e + 1 : 2), "break flag");
      check(debugException, r.brk && k == (r.vh ? e + 2 : 3), "debug exc");
      check(debugOnFetch, 1'b0, "fetch marker");
      // breaks stay enabled through the rows, so a breakpointed write never lands
      check(uSt, r.kind.wr && !r.brk && k == e + 1, "stored");
      check(uDone, k == e + 1, "done");
      check(scResultValid, r.kind.unlockReq && k == e + 2, "sc valid");
      if (scResultValid === 1'b1)
        check(scResult, r.rel, "sc result");
    end
    if (r.brk)
    begin
      check(uIdle, 1'b0, "idle while break pending");
      @(posedge clk);
      dataIssueHit <= 1'b0;
      dataValueHit <= 1'b0;
      dataStart <= 1'b1;
      @(posedge clk);
      dataStart <= 1'b0;
      @(negedge clk);
      check(uRd | uWr, 1'b0, "start dropped");
      @(posedge clk);
      debugReturn <= 1'b1;
      @(posedge clk);
      debugReturn <= 1'b0;
      @(negedge clk);
      check(uRd, r.kind.rd, "replay read");
      check(uWr, r.kind.wr, "replay write");
      repeat (e + 2) @(negedge clk);
    end
  endtask : run

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    numErrors++;
    conclude();
  end

  initial
  begin
    {resetn, unifiedMode, dataOnFetchSide, dataStart, fetchStart, debugReturn} = 6'h00;
    {exceptionReturn, dataBreakEnabled, instrBreakEnabled, dataIssueHit} = 4'h0;
    {dataValueHit, fetchIssueHit, keepLock} = 3'h0;
    dataKind = SBL_KIND_RESET;
    waitN = 4'h1;
    repeat (5) @(posedge clk);
    check(dataIdle, 1'b0, "idle in reset");
    resetn <= 1'b1;
    @(negedge clk);
    check(dataSideReadStrobe, 1'b0, "strobe after reset");
    @(negedge clk);
    check(dataIdle, 1'b1, "idle after reset");
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      {unifiedMode, instrBreakEnabled, dataBreakEnabled} <= i[2:0];
      repeat (2) @(negedge clk);
      check(dataSideBreakEnable, i[0] & ~i[2], "data enable");
      check(fetchSideBreakEnable, i[2] ? |i[1:0] : i[1], "fetch enable");
    end
    foreach (rows[i])
      run(rows[i]);
    @(posedge clk);
    unifiedMode <= 1'b0;
    dataOnFetchSide <= 1'b0;
    exceptionReturn <= 1'b1;
    @(posedge clk);
    exceptionReturn <= 1'b0;
    @(negedge clk);
    check(fetchSideReleaseEveryLock, 1'b1, "release all");
    @(negedge clk);
    check(fetchSideReleaseEveryLock, 1'b0, "release all one cycle");
    // fetch break then its replay
    @(posedge clk);
    fetchStart <= 1'b1;
    fetchIssueHit <= 1'b1;
    @(posedge clk);
    fetchStart <= 1'b0;
    @(negedge clk);
    check(fetchSideInstructionFlag & fetchSideReadStrobe, 1'b1, "fetch strobe");
    @(negedge clk);
    check(fetchSideBreakFlag, 1'b1, "fetch break");
    @(negedge clk);
    check(debugException & debugOnFetch, 1'b1, "fetch debug exc");
    repeat (3) @(posedge clk);
    fetchIssueHit <= 1'b0;
    debugReturn <= 1'b1;
    @(posedge clk);
    debugReturn <= 1'b0;
    @(negedge clk);
    check(fetchSideReadStrobe, 1'b1, "fetch replay");
    repeat (5) @(posedge clk);
    conclude();
  end
endmodule : tb_top
